//--- dual_channel_fine_pwm.v
// Two fine pulse-width modulator module instances behind an AXI4-Lite slave.
// Assumes one clock and a synchronous active-low reset; the pulse outputs
// feed external low-pass filters.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.vh"

module dual_channel_fine_pwm #(
	parameter [15:0] RES_DIV_MAX = `RES_DIV7
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire        pulse_out_0,
	output wire        pulse_out_1,
	output wire        pulse_out_2,
	output wire        pulse_out_3
);

	// A zero top period would wrap the tick compare; treat it as one.
	localparam [15:0] DIV_TOP = (RES_DIV_MAX == 16'h0000) ? 16'h0001 :
		RES_DIV_MAX;

	// Counter word packing: low byte on top, upper bits in reversed order.
	function [15:0] pack_count;
		input [13:0] c;
		input        bank;
		integer j;
		begin
			pack_count = 16'h0000;
			pack_count[15:8] = c[7:0];
			for (j = 0; j < 6; j = j + 1) begin
				pack_count[7 - j] = c[8 + j];
			end
			pack_count[`CNT_ONE_BIT] = 1'b1;
			pack_count[`BANK_BIT] = bank;
		end
	endfunction

	function [13:0] unpack_count;
		input [15:0] w;
		integer j;
		begin
			unpack_count[7:0] = w[15:8];
			for (j = 0; j < 6; j = j + 1) begin
				unpack_count[8 + j] = w[7 - j];
			end
		end
	endfunction

	function [15:0] res_period;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: res_period = `RES_DIV0;
				3'h1: res_period = `RES_DIV1;
				3'h2: res_period = `RES_DIV2;
				3'h3: res_period = `RES_DIV3;
				3'h4: res_period = `RES_DIV4;
				3'h5: res_period = `RES_DIV5;
				3'h6: res_period = `RES_DIV6;
				default: res_period = DIV_TOP;
			endcase
		end
	endfunction

	function addr_mapped;
		input [7:0] a;
		begin
			addr_mapped = (a < `PWM_MAP_END) && (a[1:0] == 2'b00);
		end
	endfunction

	// Write channel holding registers. Only the low half of the data word
	// and its two low strobes are kept, since every register is 16 bits.
	reg        aw_hold_reg;
	reg  [7:0] awaddr_reg;
	reg        w_hold_reg;
	reg [15:0] wdata_reg;
	reg  [1:0] wstrb_reg;
	wire       wr_go;
	wire       wr_full;
	wire       wr_mapped;

	// Both write channels stall while a response waits, so a second write
	// cannot land before the master has accepted the first response.
	assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go     = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign wr_full   = (wstrb_reg == 2'b11);
	assign wr_mapped = addr_mapped(awaddr_reg);

	// Address and data are caught independently so either may arrive first.
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg  <= 1'b0;
			awaddr_reg   <= 8'h00;
			w_hold_reg   <= 1'b0;
			wdata_reg    <= 16'h0000;
			wstrb_reg    <= 2'b00;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata[15:0];
				wstrb_reg  <= s_axi_wstrb[1:0];
			end
			// The write strobe waits for bvalid to drop, so the set and the
			// clear of the response flag never fall in one cycle.
			if (wr_go) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Flattened per-instance state for the read multiplexer.
	wire [27:0] count_all;
	wire [27:0] data_a_all;
	wire [27:0] data_b_all;
	wire  [1:0] cfs_a_all;
	wire  [1:0] cfs_b_all;
	wire  [1:0] bank_all;
	wire [15:0] ctrl_all;
	wire  [3:0] pulse_all;

	genvar m;
	generate
		// Each instance keeps its own divider, counter and register pair.
		for (m = 0; m < 2; m = m + 1) begin : inst
			reg  [13:0] count_reg;
			reg  [13:0] data_a_reg;
			reg  [13:0] data_b_reg;
			reg         cfs_a_reg;
			reg         cfs_b_reg;
			reg         bank_reg;
			reg   [7:0] ctrl_reg;
			reg  [15:0] div_reg;
			wire [15:0] period;
			wire        tick;
			wire        sel;
			wire        wr0;
			wire        wr1;

			assign sel = wr_go && wr_mapped &&
				(awaddr_reg[`PWM_MOD_BIT] == m);
			assign wr0 = sel && !awaddr_reg[`PWM_WORD_BIT];
			assign wr1 = sel && awaddr_reg[`PWM_WORD_BIT];
			assign period = res_period(
				ctrl_reg[`CTRL_CKS_MSB:`CTRL_CKS_LSB]);
			// The divider is as wide as the period, so any top period set
			// through RES_DIV_MAX still reaches its tick.
			assign tick = (div_reg >= period - 16'h0001);

			// A change of resolution takes effect within one new period,
			// since the compare catches an overshooting divider at once.
			always @(posedge aclk) begin
				if (!aresetn) begin
					div_reg <= 16'h0000;
				end else if (tick) begin
					div_reg <= 16'h0000;
				end else begin
					div_reg <= div_reg + 16'h0001;
				end
			end

			// Hold wins over a software write, so a stopped counter always
			// reads back as three.
			always @(posedge aclk) begin
				if (!aresetn) begin
					count_reg <= `CNT_RESET;
				end else if (ctrl_reg[`CTRL_RUN_BIT]) begin
					count_reg <= `CNT_HOLD;
				end else if (wr1 && bank_reg && wr_full) begin
					count_reg <= unpack_count(wdata_reg);
				end else if (tick) begin
					count_reg <= count_reg + 14'h0001;
				end
			end

			// Writes decode against the bank in force when they land; a
			// write that flips the bank steers only later accesses.
			always @(posedge aclk) begin
				if (!aresetn) begin
					bank_reg   <= `BANK_RESET;
					ctrl_reg   <= `CTRL_RESET;
					data_a_reg <= `DATA_RESET;
					data_b_reg <= `DATA_RESET;
					cfs_a_reg  <= `CFS_RESET;
					cfs_b_reg  <= `CFS_RESET;
				end else if (bank_reg) begin
					if (wr0 && wstrb_reg[0]) begin
						ctrl_reg <= {wdata_reg[`CTRL_RSV7_BIT],
							wdata_reg[`CTRL_RUN_BIT], 3'b000,
							wdata_reg[`CTRL_CKS_MSB:`CTRL_CKS_LSB]};
					end
					if (wr1 && wr_full) begin
						bank_reg <= wdata_reg[`BANK_BIT];
					end
				end else begin
					if (wr0 && wr_full) begin
						data_a_reg <= wdata_reg[15:2];
						cfs_a_reg  <= wdata_reg[`CFS_BIT];
					end
					if (wr1 && wr_full) begin
						data_b_reg <= wdata_reg[15:2];
						cfs_b_reg  <= wdata_reg[`CFS_BIT];
						bank_reg   <= wdata_reg[`BANK_BIT];
					end
				end
			end

			// Both channels of an instance watch the same counter.
			fine_pwm_channel chan_a (
				.aclk           (aclk),
				.aresetn        (aresetn),
				.count          (count_reg),
				.data           (data_a_reg),
				.carrier_select (cfs_a_reg),
				.pulse_out      (pulse_all[2 * m])
			);

			fine_pwm_channel chan_b (
				.aclk           (aclk),
				.aresetn        (aresetn),
				.count          (count_reg),
				.data           (data_b_reg),
				.carrier_select (cfs_b_reg),
				.pulse_out      (pulse_all[2 * m + 1])
			);

			assign count_all[14 * m +: 14]  = count_reg;
			assign data_a_all[14 * m +: 14] = data_a_reg;
			assign data_b_all[14 * m +: 14] = data_b_reg;
			assign cfs_a_all[m] = cfs_a_reg;
			assign cfs_b_all[m] = cfs_b_reg;
			assign bank_all[m]  = bank_reg;
			assign ctrl_all[8 * m +: 8] = ctrl_reg | `CTRL_ONES_MASK;
		end
	endgenerate

	// Instance 0 drives pins 0 and 1, instance 1 pins 2 and 3, A first.
	assign pulse_out_0 = pulse_all[0];
	assign pulse_out_1 = pulse_all[1];
	assign pulse_out_2 = pulse_all[2];
	assign pulse_out_3 = pulse_all[3];

	reg  [15:0] rd_word;
	reg         rd_mod;
	reg         rd_sel;

	// The word is picked while AR is offered, from the state held before
	// the edge that takes the address.
	always @* begin
		rd_mod  = s_axi_araddr[`PWM_MOD_BIT];
		rd_sel  = s_axi_araddr[`PWM_WORD_BIT];
		rd_word = 16'h0000;
		if (bank_all[rd_mod]) begin
			if (rd_sel) begin
				rd_word = pack_count(count_all[14 * rd_mod +: 14],
					bank_all[rd_mod]);
			end else begin
				rd_word = {8'h00, ctrl_all[8 * rd_mod +: 8]};
			end
		end else begin
			if (rd_sel) begin
				rd_word = {data_b_all[14 * rd_mod +: 14],
					cfs_b_all[rd_mod], bank_all[rd_mod]};
			end else begin
				rd_word = {data_a_all[14 * rd_mod +: 14],
					cfs_a_all[rd_mod], 1'b1};
			end
		end
	end

	// Unmapped or misaligned reads answer zero with an error response;
	// reads touch no state, so a stray read cannot switch a bank.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			if (addr_mapped(s_axi_araddr)) begin
				s_axi_rdata <= {16'h0000, rd_word};
				s_axi_rresp <= `RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

//--- pwm_regs.vh
// Register map, field positions, reset values and divider counts for the
// dual-channel fine pulse-width modulator.
// Assumes it is included by its bare name from each design file.
`ifndef PWM_REGS_VH
`define PWM_REGS_VH

// Byte addresses: each module instance owns two shared-address words.
`define PWM_MOD0_WORD0    8'h00
`define PWM_MOD0_WORD1    8'h04
`define PWM_MOD1_WORD0    8'h08
`define PWM_MOD1_WORD1    8'h0C
`define PWM_MAP_END       8'h10
`define PWM_MOD_BIT       3
`define PWM_WORD_BIT      2

// Control register fields.
`define CTRL_RSV7_BIT     7
`define CTRL_RUN_BIT      6
`define CTRL_CKS_MSB      2
`define CTRL_CKS_LSB      0
`define CTRL_ONES_MASK    8'h30
`define CTRL_RESET        8'h00

// Counter word fields.
`define CNT_ONE_BIT       1
`define BANK_BIT          0
`define CNT_RESET         14'h0000
`define CNT_HOLD          14'h0003
`define BANK_RESET        1'b1

// Data word fields.
`define CFS_BIT           1
`define DATA_RSV_BIT      0
`define DATA_RESET        14'h3FFF
`define CFS_RESET         1'b1
`define DATA_MIN_CFS0     14'h0100
`define DATA_MIN_CFS1     14'h0040

// Resolution periods in system clock cycles, one per clock-select code.
`define RES_DIV0          16'h0001
`define RES_DIV1          16'h0002
`define RES_DIV2          16'h0040
`define RES_DIV3          16'h0080
`define RES_DIV4          16'h0100
`define RES_DIV5          16'h0400
`define RES_DIV6          16'h1000
`define RES_DIV7          16'h4000

// AXI responses.
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

//--- fine_pwm_channel.v
// One modulated channel: compares the shared counter with its data value.
// Assumes counter and data come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.vh"

module fine_pwm_channel (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [13:0] count,
	input  wire [13:0] data,
	input  wire        carrier_select,
	output reg         pulse_out
);

	function [7:0] rev8;
		input [7:0] v;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				rev8[i] = v[7 - i];
			end
		end
	endfunction

	function [5:0] rev6;
		input [5:0] v;
		integer i;
		begin
			for (i = 0; i < 6; i = i + 1) begin
				rev6[i] = v[5 - i];
			end
		end
	endfunction

	reg  [8:0] pos;
	reg  [8:0] width;
	reg        legal;
	reg        fine;

	// Fine pulses go to base cycles whose bit-reversed index is below the
	// fine field, which spreads them evenly and keeps ripple low. With the
	// two lowest data bits at zero the top counter bits drop out of it.
	always @* begin
		if (carrier_select) begin
			pos   = {1'b0, count[7:0]};
			fine  = (rev6(count[13:8]) < data[5:0]);
			width = {1'b0, data[13:6]};
			legal = (data >= `DATA_MIN_CFS1);
		end else begin
			pos   = {3'b000, count[5:0]};
			fine  = (rev8(count[13:6]) < data[7:0]);
			width = {3'b000, data[13:8]};
			legal = (data >= `DATA_MIN_CFS0);
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			pulse_out <= 1'b0;
		end else if (!legal) begin
			pulse_out <= 1'b0;
		end else begin
			pulse_out <= (pos < width + {8'h00, fine});
		end
	end

endmodule
`default_nettype wire

//--- pwm_bus_asserts.sv
// Bus and readback assertions for the dual-channel fine modulator.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.vh"
module pwm_bus_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        pulse_out_0
);
	wire ar_go = s_axi_arvalid && s_axi_arready;
	wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire mapped = s_axi_araddr < `PWM_MAP_END;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_w_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_block: assert property (p_w_block) else $error("write taken");
	property p_b_lat;
		wr_go |=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("late response");
	property p_r_lat;
		ar_go |=> s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("late read");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read dropped");
	property p_r_upper;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_r_upper: assert property (p_r_upper) else $error("upper half set");
	property p_unmapped;
		ar_go && !mapped |=> s_axi_rresp == `RESP_SLVERR
			&& s_axi_rdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_word0_ones;
		ar_go && mapped && s_axi_araddr[2:0] == 3'h0
			|=> s_axi_rdata[0] || s_axi_rdata[5:4] == 2'b11;
	endproperty
	a_word0_ones: assert property (p_word0_ones) else $error("word0 ones");
	property p_word1_ones;
		ar_go && mapped && s_axi_araddr[2:0] == 3'h4
			|=> !s_axi_rdata[0] || s_axi_rdata[1];
	endproperty
	a_word1_ones: assert property (p_word1_ones) else $error("word1 ones");
	c_write: cover property (wr_go);
	c_unmapped: cover property (ar_go && !mapped);
	c_pulse: cover property ($rose(pulse_out_0));
endmodule
bind dual_channel_fine_pwm pwm_bus_asserts i_pwm_bus_asserts (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .pulse_out_0
);
`default_nettype wire

//--- lp_filter_model.sv
// Stand-in for the external low-pass filters on the four pulse outputs.
// Assumes the outputs are sampled on the block's own clock.
`timescale 1ns/1ps
`default_nettype none
module lp_filter_model (
	input  wire logic             aclk,
	input  wire logic             clr,
	input  wire logic [3:0]       pulse,
	output var  logic [3:0][15:0] hi
);
	// A high-cycle sum over one counter period replaces the settled analog
	// level, so no filter time constant has to be modelled.
	always @(posedge aclk) begin
		for (int i = 0; i < 4; i++) begin
			if (clr) hi[i] <= 16'h0000;
			else hi[i] <= hi[i] + {15'h0000, pulse[i]};
		end
	end
endmodule
`default_nettype wire

//--- dual_channel_fine_pwm_tb_top.sv
// Self-checking bench for the dual-channel fine modulator.
// Assumes the design, its header, the checker and the filter model.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.vh"
module dual_channel_fine_pwm_tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h00000000, rdata, d;
	logic [3:0]  ws = 4'h0;
	wire  [3:0]  po;
	logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic        awr, wrdy, bv, arr, rv;
	logic [1:0]  bresp, rresp, r;
	logic [3:0][15:0] hi;
	int          fail_count = 0, num_checks = 0;
	always #2 aclk = ~aclk;
	dual_channel_fine_pwm #(.RES_DIV_MAX(16'h0008)) i_dual_channel_fine_pwm (
		.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.pulse_out_0(po[0]), .pulse_out_1(po[1]), .pulse_out_2(po[2]),
		.pulse_out_3(po[3])
	);
	lp_filter_model i_lp_filter_model (.aclk, .clr, .pulse(po), .hi);
	task automatic chk(input string n, input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		logic aw_done, w_done;
		@(posedge aclk);
		awa <= a;
		wd <= {16'h0000, v};
		ws <= 4'h3;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		while (!aw_done || !w_done) begin
			@(posedge aclk);
			if (!aw_done && awr) begin
				aw_done = 1'b1;
				awv <= 1'b0;
			end
			if (!w_done && wrdy) begin
				w_done = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bv);
		r = bresp;
		br <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge aclk); while (!arr);
		arv <= 1'b0;
		do @(posedge aclk); while (!rv);
		d = rdata;
		r = rresp;
		rr <= 1'b0;
	endtask
	function automatic logic [15:0] cw(input logic [13:0] c);
		return {c[7:0], c[8], c[9], c[10], c[11], c[12], c[13], 2'b11};
	endfunction
	task automatic t_reset;
		rd(8'h08);
		chk("ctrl1", d, 32'h00000030);
		rd(8'h0C);
		chk("cnt1 low", d[1:0], 2'b11);
		wr(8'h04, 16'h0000);
		chk("bresp ok", r, `RESP_OKAY);
		rd(8'h00);
		chk("data a", d, 32'h0000FFFF);
		chk("rresp ok", r, `RESP_OKAY);
		rd(8'h04);
		chk("data b", d, 32'h0000FFFE);
		wr(8'h00, 16'h0000);
		rd(8'h00);
		chk("data a rsv", d, 32'h00000001);
	endtask
	task automatic t_hold;
		wr(8'h04, 16'h0001);
		wr(8'h00, 16'h00C7);
		repeat (16) @(posedge aclk);
		rd(8'h00);
		chk("ctrl0", d, 32'h000000F7);
		rd(8'h04);
		chk("held", d, 32'h00000303);
		wr(8'h04, 16'h1235);
		rd(8'h04);
		chk("held wr", d, 32'h00000303);
	endtask
	task automatic t_count;
		logic [13:0] c [2];
		c = '{14'h1234, 14'h3FFF};
		wr(8'h00, 16'h0007);
		foreach (c[i]) begin
			wr(8'h04, cw(c[i]));
			rd(8'h04);
			chk("count", d === cw(c[i]) || d === cw(c[i] + 14'h0001), 1);
		end
		wr(8'h00, 16'h0001);
		wr(8'h04, cw(14'h0000));
		repeat (64) @(posedge aclk);
		rd(8'h04);
		chk("count rate", d, cw(14'h0021));
		rd(8'h10);
		chk("unmapped rd", r, `RESP_SLVERR);
		wr(8'h14, 16'hFFFF);
		chk("unmapped wr", r, `RESP_SLVERR);
	endtask
	task automatic t_pwm;
		wr(8'h00, 16'h0000);
		wr(8'h04, 16'h0000);
		wr(8'h00, 16'h48D6);
		wr(8'h04, 16'h2AF0);
		wr(8'h0C, 16'h0000);
		wr(8'h08, 16'h00FE);
		repeat (300) @(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		repeat (16384) @(posedge aclk);
		@(negedge aclk);
		chk("out0", hi[0], 32'h00001235);
		chk("out1", hi[1], 32'h00000ABC);
		chk("out2", hi[2], 32'h00000000);
		chk("out3", hi[3], 32'h00003FFF);
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_hold();
		t_count();
		t_pwm();
		stop_test();
	end
	initial begin
		repeat (60000) @(posedge aclk);
		fail_count++;
		stop_test();
	end
endmodule
`default_nettype wire
